// ### tb/etscap_host.sv
// wishbone host model that reads the process image
`default_nettype none
module etscap_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cyc_o, stb_o, we_o} = 3'h0;
    adr_o = 8'h0;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // one classic cycle; no output image data is ever sent
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o} <= {2'b11, w};
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= wd;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = dat_i;
    {cyc_o, stb_o, we_o} <= 3'h0;
    // released lines must not keep showing the last value
    adr_o <= ~a;
    dat_o <= ~wd;
  endtask
endmodule // etscap_host
`default_nettype wire

// ### tb/etscap_top_asserts.sv
// port-level checker for the edge time stamp capture unit
`default_nettype none
module etscap_top_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [3:0] din_i,
  input wire logic bus_ok_i,
  input wire logic bus_pwr_ok_i,
  input wire logic fault_i,
  input wire logic run_led_o,
  input wire logic fault_led_o,
  input wire logic [3:0] chan_led_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***
  // checks
  // ***
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_noreq_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chan_led_a: assert property (!$past(rst_i) |-> chan_led_o == $past(din_i))
    else $error("channel indicator wrong");
  run_led_a: assert property (!$past(rst_i) |-> run_led_o == $past(bus_ok_i && bus_pwr_ok_i))
    else $error("run indicator wrong");
  pwr_dark_a: assert property (!$past(rst_i) && !$past(bus_pwr_ok_i) |->
    !run_led_o && !fault_led_o) else $error("indicators lit without power");
  fault_lit_a: assert property (!$past(rst_i) && $past(fault_i && bus_pwr_ok_i) |->
    fault_led_o) else $error("fault indicator dark on fault");
  rec_fmt_a: assert property (ack_o && !we_i && adr_i < 8'h3c |->
    dat_o[15] == 1'b0 && dat_o[7:4] == 4'h0) else $error("record padding not zero");
  unmap_rd_a: assert property (ack_o && !we_i && adr_i >= 8'h58 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // etscap_top_asserts
bind etscap_top etscap_top_asserts i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .din_i(din_i),
  .bus_ok_i(bus_ok_i), .bus_pwr_ok_i(bus_pwr_ok_i), .fault_i(fault_i),
  .run_led_o(run_led_o), .fault_led_o(fault_led_o), .chan_led_o(chan_led_o));
`default_nettype wire

// ### tb/etscap_top_tb.sv
// self-checking bench for the edge time stamp capture unit
`default_nettype none
module etscap_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, run_led, fault_led, bus_ok, pwr_ok, fault;
  logic [7:0] adr;
  logic [3:0] sel, din, chan_led;
  logic [31:0] wd, dq, rdat, t0;
  int errors, checked, ones;
  int cnt = 0;
  // din, status low byte, record address, record low half
  logic [35:0] rows [8] = '{36'h1_11_00_0101, 36'h3_23_04_0203, 36'h2_22_04_0203,
    36'h6_36_08_0306, 36'he_4e_0c_040e, 36'hf_0f_10_050f, 36'h0_00_10_050f,
    36'h8_18_00_0608};
  etscap_host i_host (.clk_i(clk_i), .ack_i(ack), .dat_i(dq), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
  etscap_top #(.BLINK_CYC(8)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(dq), .ack_o(ack), .din_i(din),
    .bus_ok_i(bus_ok), .bus_pwr_ok_i(pwr_ok), .fault_i(fault), .irq_o(irq),
    .run_led_o(run_led), .fault_led_o(fault_led), .chan_led_o(chan_led));
  // ***
  // helpers
  // ***
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus_rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, rdat);
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] wr_echo;
    i_host.xfer(1'b1, a, d, wr_echo);
  endtask
  task automatic leds(input logic [2:0] in, input logic [1:0] exp);
    {bus_ok, pwr_ok, fault} <= in;
    repeat (3) @(posedge clk_i);
    check(32'({run_led, fault_led}), 32'(exp));
  endtask
  task automatic end_sim();
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // the whole run needs about 650 cycles
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (cnt == 20000) begin
      errors++;
      end_sim();
    end
  end
  // ***
  // sequence
  // ***
  initial begin
    {rst_i, bus_ok, pwr_ok, fault, din} = 8'he0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus_rd(8'h50);
    check(rdat, 32'h0);
    bus_rd(8'h44);
    check(rdat, 32'h100);
    bus_wr(8'h40, 32'h1);
    foreach (rows[i]) begin
      din <= rows[i][35:32];
      bus_rd(8'h44);
      check(32'(rdat[7:0]), 32'(rows[i][31:24]));
      bus_rd(rows[i][23:16]);
      check(32'(rdat[15:0]), 32'(rows[i][15:0]));
      check(32'(chan_led), 32'(rows[i][35:32]));
    end
    bus_rd(8'h48);
    check(rdat, 32'h3);
    check(32'(irq), 32'h0);
    bus_wr(8'h4c, 32'h1);
    repeat (2) @(posedge clk_i);
    check(32'(irq), 32'h1);
    bus_wr(8'h48, 32'h1);
    repeat (2) @(posedge clk_i);
    check(32'(irq), 32'h0);
    bus_rd(8'h50);
    t0 = rdat;
    bus_wr(8'h40, 32'h7);
    din <= 4'h0;
    bus_rd(8'h04);
    check(32'(rdat[15:0]), 32'h0700);
    check(32'(rdat[31:16] - t0[15:0] < 16'h2), 32'h1);
    // 121 falling edges take the sequence through 127 and back to 0
    repeat (121) begin
      din <= 4'h1;
      repeat (2) @(posedge clk_i);
      din <= 4'h0;
      repeat (2) @(posedge clk_i);
    end
    bus_rd(8'h08);
    check(32'(rdat[15:0]), 32'h0);
    bus_rd(8'h44);
    check(rdat, 32'h130);
    bus_wr(8'h08, 32'hffff_ffff);
    bus_rd(8'h08);
    check(32'(rdat[15:0]), 32'h0);
    bus_rd(8'h80);
    check(rdat, 32'h0);
    leds(3'b110, 2'b10);
    leds(3'b111, 2'b11);
    leds(3'b011, 2'b01);
    leds(3'b001, 2'b00);
    leds(3'b110, 2'b10);
    // the forced fault bit must light the fault indicator with the bus healthy
    bus_wr(8'h40, 32'h17);
    leds(3'b110, 2'b11);
    bus_wr(8'h40, 32'hf);
    repeat (4) @(posedge clk_i);
    ones = 0;
    repeat (16) begin
      @(posedge clk_i);
      ones += int'(fault_led);
    end
    check(32'(ones), 32'h8);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    bus_rd(8'h44);
    check(rdat, 32'h100);
    bus_rd(8'h40);
    check(rdat, 32'h0);
    end_sim();
  end
endmodule // etscap_top_tb
`default_nettype wire

// ### verilog/etscap_cfg.svh
// constants and rule summary for the edge time stamp capture unit
// Summary of operation
// - capture timer and input state on each edge of configured polarity
// - each record carries a sequence counter value for edge order
// - configuration selects 5 records (20 bytes) or 15 records (60 bytes)
// - every record is exactly four bytes, one bus word
// - no output process image bytes are used
// - channel indicator lit while its input is one, dark while zero
// - bus ok and no fault: run lit, fault dark
// - internal fault lights fault indicator, run stays lit if bus works
// - bus communication lost turns run indicator off
// - bus power failure: run and fault indicators both dark (the code still flashes fault while the configuration error bit is set)
// - configuration error flashes fault indicator at 2 Hz
// - sequence counter starts at 1, steps per capture, wraps 0 to 127
// - 32-bit microsecond timer from zero at start, wraps at maximum
// - time field holds the low 16 bits of the timer
// - input byte holds levels after the edge in bits 0..3, bits 4..7 zero
`ifndef ETSCAP_CFG_SVH
`define ETSCAP_CFG_SVH
`define ETSCAP_CLK_MHZ 250
`define ETSCAP_US_NS 1000
`define ETSCAP_CLK_NS 4
`define ETSCAP_US_CYC (`ETSCAP_US_NS / `ETSCAP_CLK_NS)
`define ETSCAP_BLINK_MS 250
`define ETSCAP_BLINK_CYC (`ETSCAP_BLINK_MS * 1000000 / `ETSCAP_CLK_NS)
`define ETSCAP_SMALL_SLOTS 5
`define ETSCAP_LARGE_SLOTS 15
`define ETSCAP_SEQ_START 7'h01
`define ETSCAP_SEQ_MAX 7'h7f
// register byte addresses
`define ETSCAP_REC_BASE 8'h00
`define ETSCAP_CTRL 8'h40
`define ETSCAP_STAT 8'h44
`define ETSCAP_IRQ_STAT 8'h48
`define ETSCAP_IRQ_MASK 8'h4c
`define ETSCAP_TIMER 8'h50
`define ETSCAP_ID 8'h54
// ctrl field positions
`define ETSCAP_CTRL_EN 0
`define ETSCAP_CTRL_FALL 1
`define ETSCAP_CTRL_LARGE 2
`define ETSCAP_CTRL_CFGERR 3
`define ETSCAP_CTRL_FAULT 4
`define ETSCAP_CTRL_RST 32'h0000_0000
`define ETSCAP_CTRL_MASK 32'h0000_001f
// irq bits
`define ETSCAP_IRQ_CAP 0
`define ETSCAP_IRQ_WRAP 1
`endif

// ### verilog/etscap_led.sv
// module and channel status indicator logic
`include "etscap_cfg.svh"
`default_nettype none
module etscap_led #(
  parameter int BLINK_CYC = `ETSCAP_BLINK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bus_ok_i,
  input wire logic bus_pwr_ok_i,
  input wire logic fault_i,
  input wire logic cfg_err_i,
  input wire logic [3:0] din_i,
  output etscap_pkg::etscap_led_t led_o
);
  logic [31:0] blink_cnt_ff;
  logic blink_ff;
  etscap_pkg::etscap_led_st_t st;
  etscap_pkg::etscap_led_t nxt_led;
  etscap_pkg::etscap_led_t led_ff;
  // half period of 250 ms gives 2 Hz
  always_ff @(posedge clk_i) begin
    if (rst_i || blink_cnt_ff == 32'(BLINK_CYC - 1)) begin
      blink_cnt_ff <= 32'h0000_0000;
    end else begin
      blink_cnt_ff <= blink_cnt_ff + 32'h0000_0001;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blink_ff <= 1'b0;
    end else if (blink_cnt_ff == 32'(BLINK_CYC - 1)) begin
      blink_ff <= ~blink_ff;
    end
  end
  always_comb begin
    if (cfg_err_i) begin
      st = etscap_pkg::ETSCAP_LED_CFGERR;
    end else if (!bus_pwr_ok_i) begin
      st = etscap_pkg::ETSCAP_LED_NOPWR;
    end else if (!bus_ok_i) begin
      st = etscap_pkg::ETSCAP_LED_NOBUS;
    end else begin
      st = etscap_pkg::ETSCAP_LED_OK;
    end
  end
  always_comb begin
    nxt_led.channel_status_indicator = din_i;
    case (st)
      etscap_pkg::ETSCAP_LED_CFGERR: begin
        nxt_led.run = bus_ok_i && bus_pwr_ok_i;
        nxt_led.module_fault_indicator = blink_ff;
      end
      etscap_pkg::ETSCAP_LED_NOPWR: begin
        nxt_led.run = 1'b0;
        nxt_led.module_fault_indicator = 1'b0;
      end
      etscap_pkg::ETSCAP_LED_NOBUS: begin
        nxt_led.run = 1'b0;
        nxt_led.module_fault_indicator = fault_i;
      end
      default: begin
        nxt_led.run = 1'b1;
        nxt_led.module_fault_indicator = fault_i;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_ff <= '0;
    end else begin
      led_ff <= nxt_led;
    end
  end
  assign led_o = led_ff;
endmodule // etscap_led
`default_nettype wire

// ### verilog/etscap_pkg.sv
// types for the edge time stamp capture unit
`default_nettype none
package etscap_pkg;
  typedef struct packed {
    logic [15:0] captured_time_low;
    logic [7:0] sequence_counter;
    logic [7:0] input_process_image;
  } etscap_rec_t;
  typedef struct packed {
    logic run;
    logic module_fault_indicator;
    logic [3:0] channel_status_indicator;
  } etscap_led_t;
  typedef enum logic [3:0] {
    ETSCAP_LED_OK = 4'h1,
    ETSCAP_LED_NOBUS = 4'h2,
    ETSCAP_LED_NOPWR = 4'h4,
    ETSCAP_LED_CFGERR = 4'h8
  } etscap_led_st_t;
endpackage
`default_nettype wire

// ### verilog/etscap_timer.sv
// free-running 32-bit microsecond timer
`include "etscap_cfg.svh"
`default_nettype none
module etscap_timer #(
  parameter int US_CYC = `ETSCAP_US_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic [31:0] us_o
);
  logic [15:0] pre_ff;
  logic [31:0] us_ff;
  // prescaler turns clock into one microsecond tick
  always_ff @(posedge clk_i) begin
    if (rst_i || pre_ff == 16'(US_CYC - 1)) begin
      pre_ff <= 16'h0000;
    end else begin
      pre_ff <= pre_ff + 16'h0001;
    end
  end
  // natural wrap at 2^32-1 back to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      us_ff <= 32'h0000_0000;
    end else if (pre_ff == 16'(US_CYC - 1)) begin
      us_ff <= us_ff + 32'h0000_0001;
    end
  end
  assign us_o = us_ff;
endmodule // etscap_timer
`default_nettype wire

// ### verilog/etscap_top.sv
// edge time stamp capture unit with wishbone register access
//
// Local design decisions: the Wishbone register port and the address map.
`include "etscap_cfg.svh"
`default_nettype none
module etscap_top #(
  parameter int MAX_SLOTS = `ETSCAP_LARGE_SLOTS,
  parameter int BLINK_CYC = `ETSCAP_BLINK_CYC,
  parameter logic [31:0] ID_VALUE = 32'h0000_a5a5 // identity value, arbitrary
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [3:0] din_i,
  input wire logic bus_ok_i,
  input wire logic bus_pwr_ok_i,
  input wire logic fault_i,
  output logic irq_o,
  output logic run_led_o,
  output logic fault_led_o,
  output logic [3:0] chan_led_o
);
  // ************************************************************
  // state
  // ************************************************************
  etscap_pkg::etscap_rec_t rec_ff [MAX_SLOTS];
  logic [31:0] ctrl_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic [3:0] din_prev_ff;
  logic [3:0] wr_idx_ff;
  logic [6:0] seq_ff;
  logic [31:0] dat_ff;
  logic ack_ff;
  logic [31:0] us;
  logic edge_hit;
  logic [3:0] slots;
  logic last_slot;
  logic req;
  etscap_pkg::etscap_led_t led;

  // merge byte lanes into a register
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  etscap_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .us_o(us)
  );

  etscap_led #(
    .BLINK_CYC(BLINK_CYC)
  ) u_led (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bus_ok_i(bus_ok_i),
    .bus_pwr_ok_i(bus_pwr_ok_i),
    .fault_i(fault_i | ctrl_ff[`ETSCAP_CTRL_FAULT]),
    .cfg_err_i(ctrl_ff[`ETSCAP_CTRL_CFGERR]),
    .din_i(din_i),
    .led_o(led)
  );

  // ************************************************************
  // edge detection and record writing
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      din_prev_ff <= 4'h0;
    end else begin
      din_prev_ff <= din_i;
    end
  end

  // any channel moving in the chosen direction counts as one edge
  always_comb begin
    if (ctrl_ff[`ETSCAP_CTRL_FALL]) begin
      edge_hit = ctrl_ff[`ETSCAP_CTRL_EN] && |(din_prev_ff & ~din_i);
    end else begin
      edge_hit = ctrl_ff[`ETSCAP_CTRL_EN] && |(~din_prev_ff & din_i);
    end
  end

  assign slots = ctrl_ff[`ETSCAP_CTRL_LARGE] ? 4'(`ETSCAP_LARGE_SLOTS)
                                               : 4'(`ETSCAP_SMALL_SLOTS);
  // an index left past the end by a size change wraps at once, never beyond the array
  assign last_slot = (wr_idx_ff >= slots - 4'h1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_idx_ff <= 4'h0;
    end else if (edge_hit) begin
      wr_idx_ff <= last_slot ? 4'h0 : wr_idx_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_ff <= `ETSCAP_SEQ_START;
    end else if (edge_hit) begin
      seq_ff <= (seq_ff == `ETSCAP_SEQ_MAX) ? 7'h00 : seq_ff + 7'h01;
    end
  end

  // the array has no reset; slots read back as whatever was last stored
  always_ff @(posedge clk_i) begin
    if (edge_hit) begin
      rec_ff[wr_idx_ff].input_process_image <= {4'h0, din_i};
      rec_ff[wr_idx_ff].sequence_counter <= {1'b0, seq_ff};
      rec_ff[wr_idx_ff].captured_time_low <= us[15:0];
    end
  end

  // ************************************************************
  // wishbone slave
  // ************************************************************
  assign req = cyc_i && stb_i && !ack_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= `ETSCAP_CTRL_RST;
    end else if (req && we_i && adr_i == `ETSCAP_CTRL) begin
      ctrl_ff <= wmerge(ctrl_ff, dat_i, sel_i) & `ETSCAP_CTRL_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= 2'h0;
    end else if (req && we_i && adr_i == `ETSCAP_IRQ_MASK && sel_i[0]) begin
      irq_mask_ff <= dat_i[1:0];
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= 2'h0;
    end else begin
      irq_stat_ff <= (irq_stat_ff
                      & ~((req && we_i && adr_i == `ETSCAP_IRQ_STAT && sel_i[0])
                          ? dat_i[1:0] : 2'h0))
                     | {edge_hit && last_slot, edge_hit};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (req && !we_i) begin
      if (adr_i < 8'(MAX_SLOTS * 4) && adr_i[1:0] == 2'b00) begin
        dat_ff <= rec_ff[adr_i[5:2]];
      end else if (adr_i == `ETSCAP_CTRL) begin
        dat_ff <= ctrl_ff;
      end else if (adr_i == `ETSCAP_STAT) begin
        dat_ff <= {17'h0, seq_ff, wr_idx_ff, din_i};
      end else if (adr_i == `ETSCAP_IRQ_STAT) begin
        dat_ff <= {30'h0, irq_stat_ff};
      end else if (adr_i == `ETSCAP_IRQ_MASK) begin
        dat_ff <= {30'h0, irq_mask_ff};
      end else if (adr_i == `ETSCAP_TIMER) begin
        dat_ff <= us;
      end else if (adr_i == `ETSCAP_ID) begin
        dat_ff <= ID_VALUE; // arbitrary value
      end else begin
        dat_ff <= 32'h0000_0000;
      end
    end
  end

  assign dat_o = dat_ff;
  assign ack_o = ack_ff;
  // no output image: writes to record slots are acked and dropped
  assign irq_o = |(irq_stat_ff & irq_mask_ff);
  assign run_led_o = led.run;
  assign fault_led_o = led.module_fault_indicator;
  assign chan_led_o = led.channel_status_indicator;
endmodule // etscap_top
`default_nettype wire
